// [shared/timer_sleep_consts.svh]
// Constants for the sleep-capable 16-bit timer: register offsets, field positions and reset values.
`ifndef TIMER_SLEEP_CONSTS_SVH
`define TIMER_SLEEP_CONSTS_SVH
`define ADDR_W 4
`define REG_CONTROL 4'h0
`define REG_COUNT 4'h1
`define REG_CCP 4'h2
`define REG_STATUS 4'h3
`define REG_CLEAR 4'h4
`define REG_ENABLE 4'h5
`define CTL_RUN 0
`define CTL_SYNC_DIS_N 1
`define CTL_CLK_SEL 2
`define CTL_OSC_EN 3
`define CTL_CCP_MODE_LO 4
`define CTL_SPECIAL 6
`define CTL_GIE 7
`define CTL_PEIE 8
`define CTL_RESET 16'h0000
`define EV_OVF 0
`define EV_CAPTURE 1
`define EV_MATCH 2
`define EV_W 3
`endif

// [shared/timer_sleep_pkg.sv]
// Types shared by the sleep-capable 16-bit timer.
package timer_sleep_pkg;
  typedef enum logic [1:0] {
    ccp_off,
    ccp_capture,
    ccp_compare
  } ccp_mode_e;
  typedef struct packed {
    logic write;
    logic read;
    logic [3:0] addr;
    logic [15:0] wdata;
  } bus_req_s;
  typedef struct packed {
    logic wake;
    logic isr_call;
  } wake_s;
endpackage

// [hw/timer_sleep_ccp.sv]
// Sleep-capable 16-bit timer with capture/compare time base and special event clear.
//
// Decided for this implementation: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "timer_sleep_consts.svh"
module timer_sleep_ccp
  import timer_sleep_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire bus_req_s bus_in,
  output logic [15:0] rdata_out,
  input wire logic sleep_in,
  input wire logic instr_tick_in,
  input wire logic osc_tick_in,
  input wire logic capture_event_in,
  input wire logic ext_trigger_in,
  output logic irq_out,
  output wake_s wake_out,
  output logic compare_event_out,
  output logic osc_enable_out
);
  // Register copies and the sticky event state.
  logic [15:0] control;
  logic [15:0] count_pair;
  logic [15:0] capture_compare_pair;
  logic [`EV_W-1:0] status;
  logic [`EV_W-1:0] irq_enable;

  // Decoded control fields and the overflow interrupt enable.
  logic timer_run_enable;
  logic sync_disable_n;
  logic count_clock_select;
  logic secondary_osc_enable;
  logic special_enable;
  logic global_irq_enable;
  logic peripheral_irq_enable;
  logic overflow_irq_enable;
  ccp_mode_e ccp_mode;

  // One-cycle strobes decoded from the register port.
  logic write_control;
  logic write_count;
  logic write_ccp;
  logic write_clear;
  logic write_enable;

  // Counting path.
  logic async_mode;
  logic count_tick;
  logic count_step;
  logic wrap;
  logic match;
  logic capture_now;
  logic special_clear;

  // Next values of every register and output.
  logic [15:0] next_control;
  logic [15:0] next_count_pair;
  logic [15:0] next_capture_compare_pair;
  logic [`EV_W-1:0] next_status;
  logic [`EV_W-1:0] next_irq_enable;
  logic [`EV_W-1:0] events;
  logic next_irq;
  logic next_compare_event;
  logic next_osc_enable;
  wake_s next_wake;
  logic [15:0] next_rdata;

  // Field decode is kept in one place so the rest of the logic reads by name.
  assign timer_run_enable = control[`CTL_RUN];
  assign sync_disable_n = control[`CTL_SYNC_DIS_N];
  assign count_clock_select = control[`CTL_CLK_SEL];
  assign secondary_osc_enable = control[`CTL_OSC_EN];
  assign special_enable = control[`CTL_SPECIAL];
  assign global_irq_enable = control[`CTL_GIE];
  assign peripheral_irq_enable = control[`CTL_PEIE];
  assign overflow_irq_enable = irq_enable[`EV_OVF];

  always_comb begin
    case (control[`CTL_CCP_MODE_LO +: 2])
      2'h1: ccp_mode = ccp_capture;
      2'h2: ccp_mode = ccp_compare;
      default: ccp_mode = ccp_off;
    endcase
  end

  // Writes to the status register or to unmapped offsets decode to nothing and are dropped.
  always_comb begin
    write_control = 1'b0;
    write_count = 1'b0;
    write_ccp = 1'b0;
    write_clear = 1'b0;
    write_enable = 1'b0;
    if (bus_in.write) begin
      case (bus_in.addr)
        `REG_CONTROL: write_control = 1'b1;
        `REG_COUNT: write_count = 1'b1;
        `REG_CCP: write_ccp = 1'b1;
        `REG_CLEAR: write_clear = 1'b1;
        `REG_ENABLE: write_enable = 1'b1;
        default: write_control = 1'b0;
      endcase
    end
  end

  // Asynchronous counting means the oscillator path with synchronisation bypassed.
  assign async_mode = count_clock_select && sync_disable_n;

  // In sleep the instruction clock is gone, so only the async oscillator path may count.
  always_comb begin
    if (count_clock_select) begin
      count_tick = osc_tick_in && secondary_osc_enable;
    end else begin
      count_tick = instr_tick_in;
    end
    if (sleep_in && !async_mode) begin
      count_tick = 1'b0;
    end
  end

  assign count_step = timer_run_enable && count_tick;
  assign match = (ccp_mode == ccp_compare) && (count_pair == capture_compare_pair);
  assign capture_now = (ccp_mode == ccp_capture) && capture_event_in;
  // The trigger is honoured in async mode too, but may be missed there by the prescaling logic outside.
  assign special_clear = (match && special_enable) || ext_trigger_in;
  // A wrap counts only when the increment really lands, so a trigger clear never flags an overflow.
  assign wrap = count_step && !write_count && !special_clear && (count_pair == 16'hFFFF);

  always_comb begin
    next_control = control;
    if (write_control) begin
      next_control = bus_in.wdata;
    end
  end

  // Priority: software write, then trigger clear, then increment.
  always_comb begin
    next_count_pair = count_pair;
    if (write_count) begin
      next_count_pair = bus_in.wdata;
    end else if (special_clear) begin
      next_count_pair = 16'h0000;
    end else if (count_step) begin
      next_count_pair = count_pair + 16'h0001;
    end
  end

  // A capture beats a software write in the same cycle, so a measured event is never lost.
  always_comb begin
    next_capture_compare_pair = capture_compare_pair;
    if (capture_now) begin
      next_capture_compare_pair = count_pair;
    end else if (write_ccp) begin
      next_capture_compare_pair = bus_in.wdata;
    end
  end

  always_comb begin
    next_irq_enable = irq_enable;
    if (write_enable) begin
      next_irq_enable = bus_in.wdata[`EV_W-1:0];
    end
  end

  // Special clear has no path into the overflow bit; only a true wrap sets it.
  always_comb begin
    events = '0;
    events[`EV_OVF] = wrap;
    events[`EV_CAPTURE] = capture_now;
    events[`EV_MATCH] = match;
    next_status = status;
    if (write_clear) begin
      next_status = next_status & ~bus_in.wdata[`EV_W-1:0];
    end
    // Setting after clearing lets an event in the clear cycle survive.
    next_status = next_status | events;
  end

  always_comb begin
    next_irq = |(next_status & next_irq_enable);
    next_compare_event = match;
    next_osc_enable = secondary_osc_enable;
  end

  // Wake needs a real overflow in sleep with the overflow and peripheral enables set.
  always_comb begin
    next_wake = '0;
    if (wrap && sleep_in && overflow_irq_enable && peripheral_irq_enable) begin
      next_wake.wake = 1'b1;
      next_wake.isr_call = global_irq_enable;
    end
  end

  // Read data stand for one cycle only; an idle port and the clear register read zero.
  always_comb begin
    next_rdata = 16'h0000;
    if (bus_in.read) begin
      case (bus_in.addr)
        `REG_CONTROL: next_rdata = control;
        `REG_COUNT: next_rdata = count_pair;
        `REG_CCP: next_rdata = capture_compare_pair;
        `REG_STATUS: next_rdata = {13'h0000, status};
        `REG_ENABLE: next_rdata = {13'h0000, irq_enable};
        default: next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      control <= `CTL_RESET;
    end else begin
      control <= next_control;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      count_pair <= 16'h0000;
    end else begin
      count_pair <= next_count_pair;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      capture_compare_pair <= 16'h0000;
    end else begin
      capture_compare_pair <= next_capture_compare_pair;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      status <= '0;
    end else begin
      status <= next_status;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      irq_enable <= '0;
    end else begin
      irq_enable <= next_irq_enable;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= next_irq;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      compare_event_out <= 1'b0;
    end else begin
      compare_event_out <= next_compare_event;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      osc_enable_out <= 1'b0;
    end else begin
      osc_enable_out <= next_osc_enable;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      wake_out <= '0;
    end else begin
      wake_out <= next_wake;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      rdata_out <= 16'h0000;
    end else begin
      rdata_out <= next_rdata;
    end
  end
endmodule
`default_nettype wire

// [testbench/timer_sleep_partner.sv]
// Far-side model: secondary oscillator ticks and a wake observer.
`timescale 1ns/1ps
`default_nettype none
module timer_sleep_partner
  import timer_sleep_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic osc_enable_in,
  input wire wake_s wake_in,
  output logic osc_tick_out,
  output logic [1:0] seen_out
);
  logic [1:0] div;
  // The crystal is slower than the core, so it ticks once every four cycles.
  always_ff @(posedge ref_clk_in) begin
    div <= reset_in ? 2'h0 : div + 2'h1;
    osc_tick_out <= !reset_in && osc_enable_in && div == 2'h3;
  end
  always_ff @(posedge ref_clk_in) begin
    seen_out <= reset_in ? 2'h0 : seen_out | wake_in;
  end
endmodule
`default_nettype wire

// [testbench/timer_sleep_ccp_chk.sv]
// Port assertions for the sleep timer.
`timescale 1ns/1ps
`default_nettype none
module timer_sleep_ccp_chk
  import timer_sleep_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire bus_req_s bus_in,
  input wire logic [15:0] rdata_out,
  input wire logic sleep_in,
  input wire logic instr_tick_in,
  input wire logic osc_tick_in,
  input wire logic capture_event_in,
  input wire logic ext_trigger_in,
  input wire logic irq_out,
  input wire wake_s wake_out,
  input wire logic compare_event_out,
  input wire logic osc_enable_out
);
  logic cause;
  assign cause = instr_tick_in | osc_tick_in | capture_event_in | ext_trigger_in | bus_in.write;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  property p_wk; wake_out.wake |-> $past(sleep_in); endproperty
  a_wk: assert property (p_wk) else $error("wake while awake");
  property p_wp; wake_out.wake |=> !wake_out.wake; endproperty
  a_wp: assert property (p_wp) else $error("wake too long");
  property p_is; wake_out.isr_call |-> wake_out.wake; endproperty
  a_is: assert property (p_is) else $error("isr without wake");
  property p_wt; wake_out.wake |-> $past(osc_tick_in) || $past(osc_tick_in, 2); endproperty
  a_wt: assert property (p_wt) else $error("wake without tick");
  property p_os; !$past(bus_in.write) && !$past(bus_in.write, 2) |-> $stable(osc_enable_out); endproperty
  a_os: assert property (p_os) else $error("osc enable moved");
  property p_cm; $changed(compare_event_out) |-> $past(cause) || $past(cause, 2) || $past(cause, 3); endproperty
  a_cm: assert property (p_cm) else $error("compare moved alone");
  property p_ir; $rose(irq_out) |-> $past(cause) || $past(cause, 2) || $past(cause, 3); endproperty
  a_ir: assert property (p_ir) else $error("irq rose alone");
  property p_if; $fell(irq_out) |-> $past(bus_in.write) || $past(bus_in.write, 2); endproperty
  a_if: assert property (p_if) else $error("irq fell alone");
  c_wk: cover property (wake_out.isr_call);
  c_cm: cover property ($rose(compare_event_out));
  c_ir: cover property ($fell(irq_out));
endmodule
bind timer_sleep_ccp timer_sleep_ccp_chk i_chk (.*);
`default_nettype wire

// [testbench/tb.sv]
// Directed bench for the sleep timer.
`timescale 1ns/1ps
`default_nettype none
`include "timer_sleep_consts.svh"
module tb
  import timer_sleep_pkg::*;
;
  logic clk = 0, rst = 1, sleep = 0, irq, cmp, osc_en, otick;
  logic [2:0] ev = '0;
  logic [1:0] seen;
  logic [15:0] rdata;
  bus_req_s bus = '0;
  wake_s wake;
  int miscompares = 0, num_checks = 0, cyc = 0;
  always #25 clk = ~clk;
  timer_sleep_ccp i_dut (.ref_clk_in(clk), .reset_in(rst), .bus_in(bus), .rdata_out(rdata), .sleep_in(sleep),
    .instr_tick_in(ev[0]), .osc_tick_in(otick), .capture_event_in(ev[1]), .ext_trigger_in(ev[2]),
    .irq_out(irq), .wake_out(wake), .compare_event_out(cmp), .osc_enable_out(osc_en));
  timer_sleep_partner i_far (.ref_clk_in(clk), .reset_in(rst), .osc_enable_in(osc_en), .wake_in(wake),
    .osc_tick_out(otick), .seen_out(seen));
  task automatic close_out;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // Events ride along with a write so that a tick can share a cycle with it.
  task automatic wr(input logic [3:0] a, input logic [15:0] d, input logic [2:0] v = 3'h0);
    @(posedge clk);
    bus <= '{1'h1, 1'h0, a, d};
    ev <= v;
    @(posedge clk);
    bus <= '0;
    ev <= '0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    bus <= '{1'h0, 1'h1, a, 16'h0000};
    @(posedge clk);
    bus <= '0;
    #1 chk($sformatf("reg %h", a), rdata, e);
  endtask
  always @(posedge clk) begin
    if (++cyc == 3000) begin
      miscompares++;
      close_out();
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    rd(`REG_CONTROL, `CTL_RESET);
    wr(`REG_ENABLE, 16'h0001);
    rd(`REG_ENABLE, 16'h0001);
    wr(`REG_COUNT, 16'hFFFE);
    wr(`REG_CONTROL, 16'h0001);
    wr(4'hF, 16'h0000, 3'h1);
    rd(`REG_COUNT, 16'hFFFF);
    wr(4'hF, 16'h0000, 3'h1);
    rd(`REG_COUNT, 16'h0000);
    rd(`REG_STATUS, 16'h0001);
    chk("irq", 16'(irq), 16'h0001);
    wr(`REG_CLEAR, 16'h0007);
    rd(`REG_STATUS, 16'h0000);
    wr(`REG_COUNT, 16'h0050);
    wr(4'hF, 16'h0000, 3'h4);
    rd(`REG_COUNT, 16'h0000);
    rd(`REG_STATUS, 16'h0000);
    wr(`REG_COUNT, 16'h0777, 3'h4);
    rd(`REG_COUNT, 16'h0777);
    wr(`REG_CONTROL, 16'h0010);
    wr(`REG_COUNT, 16'h1234);
    wr(4'hF, 16'h0000, 3'h2);
    rd(`REG_CCP, 16'h1234);
    wr(`REG_CLEAR, 16'h0007);
    wr(`REG_CCP, 16'h0002);
    wr(`REG_COUNT, 16'h0000);
    wr(`REG_CONTROL, 16'h0061);
    wr(4'hF, 16'h0000, 3'h1);
    wr(4'hF, 16'h0000, 3'h1);
    @(posedge clk);
    #1 chk("cmp", 16'(cmp), 16'h0001);
    rd(4'hF, 16'h0000);
    rd(`REG_COUNT, 16'h0000);
    rd(`REG_STATUS, 16'h0004);
    wr(4'hF, 16'h0000, 3'h1);
    rd(`REG_COUNT, 16'h0001);
    wr(`REG_CONTROL, 16'h0001);
    wr(`REG_COUNT, 16'h0010);
    @(posedge clk);
    sleep <= 1'h1;
    wr(4'hF, 16'h0000, 3'h1);
    rd(`REG_COUNT, 16'h0010);
    wr(`REG_COUNT, 16'hFFFF);
    wr(`REG_CONTROL, 16'h018F);
    repeat (40) if (seen == 2'h0) @(negedge clk);
    chk("wake", 16'(seen), 16'h0003);
    chk("osc", 16'(osc_en), 16'h0001);
    close_out();
  end
endmodule
`default_nettype wire
